// ===== logic/ppt_timing_gen.sv
`timescale 1ns/1ps
// Contract
// [RQ1] First-LED sample window closes when the counter equals its end count.
// [RQ2] First LED turns on when the counter equals its on-start count.
// [RQ3] First LED turns off when the counter equals its on-end count.
// [RQ4] First-LED ambient sample window opens at its start count.
// [RQ5] First-LED ambient sample window closes at its end count.
// [RQ6] Second-LED sample window opens at its start count.
// [RQ7] Second-LED sample window closes at its end count.
// [RQ8] Second LED turns on at its on-start count.
// [RQ9] Second LED turns off at its on-end count.
// [RQ10] Second-LED ambient sample window opens at its start count.
// [RQ11] Second-LED ambient sample window closes at its end count.
// [RQ12] First-LED conversion phase starts at its start count.
// [RQ13] First-LED conversion phase ends at its end count.
// [RQ14] First-LED ambient conversion starts at its start count.
// [RQ15] All counts are cycles of the 4 MHz timer clock.
// [RQ16] Counts are measured from the start of each repetition period.
// [RQ17] Host writes zeros to bits 23 to 16 of every count register.
// [RQ18] Every timing count register holds zero after reset.
// [RQ19] Timer-counter hold bit set keeps all counters in reset.
// [RQ20] Windows open on the start-count clock and close on the end-count clock.
// [RQ21] Period counter wraps to zero after the programmed period length.
module ppt_timing_gen
    import ppt_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               srst,
    // Register port
    input  wire logic               reg_wr_en,
    input  wire logic               reg_rd_en,
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    output logic      [DATA_W-1:0]  reg_rdata,
    output logic                    reg_rvalid,
    // Phase windows
    output logic                    led_b_on,
    output logic                    led_a_on,
    output logic                    led_b_sample,
    output logic                    led_a_sample,
    output logic                    amb_b_sample,
    output logic                    amb_a_sample,
    output logic                    led_b_convert,
    output logic                    amb_b_convert,
    // Counter state
    output logic      [COUNT_W-1:0] period_count
);

    ppt_timing_if tim ();

    logic [COUNT_W-1:0] count_q [NUM_SLOT];
    logic [COUNT_W-1:0] period_q;
    logic               hold_q;
    logic               read_en_q;
    logic               sw_rst_q;
    logic               first_q;
    logic [2:0]         div_q;
    logic [2:0]         div_d;
    logic [COUNT_W-1:0] cnt_q;
    logic [COUNT_W-1:0] cnt_d;
    logic [DATA_W-1:0]  rdata_q;
    logic               rvalid_q;

    logic               clr;
    logic               tick;
    logic               step;
    logic               at_end;
    logic               wr_ctrl;
    logic               wr_count;
    logic               wr_period;
    logic [SLOT_W-1:0]  wr_slot;
    logic [SLOT_W-1:0]  rd_slot;
    logic [COUNT_W-1:0] rd_value;
    logic [DATA_W-1:0]  rdata_d;

    logic [COUNT_W-1:0] win_start [NUM_WIN];
    logic [COUNT_W-1:0] win_end   [NUM_WIN];
    logic [NUM_WIN-1:0] win;
    logic [NUM_WIN-1:0] opens;
    logic [NUM_WIN-1:0] closes;

    // Register decode.

    // A software reset clears everything a hardware reset does except the read data and valid registers, one cycle after the write.
    assign clr       = srst || sw_rst_q;
    assign wr_ctrl   = reg_wr_en && (reg_addr == ADDR_CONTROL);
    assign wr_count  = reg_wr_en && is_count_addr(reg_addr);
    assign wr_period = reg_wr_en && (reg_addr == ADDR_PERIOD_LENGTH);
    assign wr_slot   = slot_of(reg_addr);
    assign rd_slot   = slot_of(reg_addr);

    // Only the low sixteen bits are kept; the upper byte is assumed zero.
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            for (int i = 0; i < NUM_SLOT; i++) begin
                count_q[i] <= COUNT_RESET; // RQ18
            end
        end else if (wr_count) begin
            count_q[wr_slot] <= reg_wdata[COUNT_W-1:0]; // RQ17
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            period_q <= PERIOD_RESET;
        end else if (wr_period) begin
            period_q <= reg_wdata[COUNT_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            hold_q    <= 1'b0;
            read_en_q <= 1'b0;
        end else if (wr_ctrl) begin
            hold_q    <= reg_wdata[CTRL_HOLD_BIT]; // RQ19
            read_en_q <= reg_wdata[CTRL_READ_EN_BIT];
        end
    end

    // The software reset bit is a one-cycle pulse and clears itself.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sw_rst_q <= 1'b0;
        end else begin
            sw_rst_q <= wr_ctrl && reg_wdata[CTRL_SW_RST_BIT];
        end
    end

    // Read path. The control register is write-only and reads as zero,
    // and every read returns zero until readout has been enabled.

    assign rd_value = is_count_addr(reg_addr) ? count_q[rd_slot]
                    : (reg_addr == ADDR_PERIOD_LENGTH) ? period_q
                    : COUNT_RESET;
    assign rdata_d  = read_en_q ? {8'h00, rd_value} : 24'h000000; // RQ17

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q  <= 24'h000000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd_en;
            if (reg_rd_en) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    // Timer clock: one enable pulse every TICK_DIV system clocks.

    assign tick  = (div_q == DIV_LAST) && !hold_q; // RQ15
    assign div_d = (hold_q || tick) ? 3'h0 : 3'(div_q + 3'h1);

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_d;
        end
    end

    // Period counter.

    assign at_end = (cnt_q == period_q);
    always_comb begin
        if (hold_q) begin
            cnt_d = COUNT_RESET; // RQ19
        end else if (tick && at_end) begin
            cnt_d = COUNT_RESET; // RQ21
        end else if (tick) begin
            cnt_d = cnt_q + 16'h0001; // RQ16
        end else begin
            cnt_d = cnt_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clr) begin
            cnt_q <= COUNT_RESET;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Without this extra step, windows starting at count zero would be
    // missed in the first period after reset or after the hold is released.
    always_ff @(posedge sys_clk) begin
        if (clr) begin
            first_q <= 1'b1;
        end else begin
            first_q <= hold_q;
        end
    end

    assign step           = tick || (first_q && !hold_q);
    assign tim.step       = step;
    assign tim.clear      = hold_q || sw_rst_q; // RQ19
    assign tim.count_next = cnt_d;
    assign period_count   = cnt_q;

    // Window edge selection.

    assign win_start[WIN_LED_B_SAMPLE]  = count_q[slot_of(ADDR_LED_B_SAMPLE_START)];
    assign win_end[WIN_LED_B_SAMPLE]    = count_q[slot_of(ADDR_LED_B_SAMPLE_END)]; // RQ1
    assign win_start[WIN_LED_B_ON]      = count_q[slot_of(ADDR_LED_B_ON_START)]; // RQ2
    assign win_end[WIN_LED_B_ON]        = count_q[slot_of(ADDR_LED_B_ON_END)]; // RQ3
    assign win_start[WIN_AMB_B_SAMPLE]  = count_q[slot_of(ADDR_AMB_B_SAMPLE_START)]; // RQ4
    assign win_end[WIN_AMB_B_SAMPLE]    = count_q[slot_of(ADDR_AMB_B_SAMPLE_END)]; // RQ5
    assign win_start[WIN_LED_A_SAMPLE]  = count_q[slot_of(ADDR_LED_A_SAMPLE_START)]; // RQ6
    assign win_end[WIN_LED_A_SAMPLE]    = count_q[slot_of(ADDR_LED_A_SAMPLE_END)]; // RQ7
    assign win_start[WIN_LED_A_ON]      = count_q[slot_of(ADDR_LED_A_ON_START)]; // RQ8
    assign win_end[WIN_LED_A_ON]        = count_q[slot_of(ADDR_LED_A_ON_END)]; // RQ9
    assign win_start[WIN_AMB_A_SAMPLE]  = count_q[slot_of(ADDR_AMB_A_SAMPLE_START)]; // RQ10
    assign win_end[WIN_AMB_A_SAMPLE]    = count_q[slot_of(ADDR_AMB_A_SAMPLE_END)]; // RQ11
    assign win_start[WIN_LED_B_CONVERT] = count_q[slot_of(ADDR_LED_B_CONVERT_START)]; // RQ12
    assign win_end[WIN_LED_B_CONVERT]   = count_q[slot_of(ADDR_LED_B_CONVERT_END)]; // RQ13
    assign win_start[WIN_AMB_B_CONVERT] = count_q[slot_of(ADDR_AMB_B_CONVERT_START)]; // RQ14
    assign win_end[WIN_AMB_B_CONVERT]   = count_q[slot_of(ADDR_AMB_B_CONVERT_END)];

    for (genvar g = 0; g < NUM_WIN; g++) begin : g_win
        ppt_window u_win (
            .sys_clk   (sys_clk),
            .srst      (srst),
            .tim       (tim.win),
            .start_cnt (win_start[g]),
            .end_cnt   (win_end[g]),
            .win_q     (win[g])
        );
    end

    assign led_b_sample  = win[WIN_LED_B_SAMPLE];
    assign led_b_on      = win[WIN_LED_B_ON];
    assign amb_b_sample  = win[WIN_AMB_B_SAMPLE];
    assign led_a_sample  = win[WIN_LED_A_SAMPLE];
    assign led_a_on      = win[WIN_LED_A_ON];
    assign amb_a_sample  = win[WIN_AMB_A_SAMPLE];
    assign led_b_convert = win[WIN_LED_B_CONVERT];
    assign amb_b_convert = win[WIN_AMB_B_CONVERT];

    // The checks below restate each window's edge match so no rule leans on the cell's own logic.
    for (genvar g = 0; g < NUM_WIN; g++) begin : g_edge
        assign opens[g]  = step && (cnt_d == win_start[g]) && (cnt_d != win_end[g]);
        assign closes[g] = step && (cnt_d == win_end[g]);
    end

    // Checks.

    AST_TICK_SPACING: assert property (@(posedge sys_clk) disable iff (clr || hold_q) // RQ15
        tick |=> !tick [*4] ##1 tick)
        else $error("timer tick spacing is not five system clocks");

    AST_COUNT_STEP: assert property (@(posedge sys_clk) disable iff (clr) // RQ16
        tick && !at_end |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
        else $error("period counter did not advance by one on a tick");

    AST_COUNT_STILL: assert property (@(posedge sys_clk) disable iff (clr) // RQ15
        !tick && !hold_q |=> cnt_q == $past(cnt_q))
        else $error("period counter moved without a tick");

    AST_WRAP: assert property (@(posedge sys_clk) disable iff (clr) // RQ21
        tick && at_end |=> cnt_q == COUNT_RESET)
        else $error("period counter did not wrap at the period length");

    AST_HOLD: assert property (@(posedge sys_clk) disable iff (srst) // RQ19
        hold_q |=> cnt_q == COUNT_RESET && win == '0 && !tick)
        else $error("counters or windows ran while held");

    AST_RESET_ZERO: assert property (@(posedge sys_clk) // RQ18
        srst |=> count_q[0] == COUNT_RESET && count_q[NUM_SLOT-1] == COUNT_RESET && period_q == PERIOD_RESET)
        else $error("timing count registers not zero after reset");

    AST_LOW_BITS_KEPT: assert property (@(posedge sys_clk) disable iff (clr) // RQ17
        wr_count |=> count_q[$past(wr_slot)] == $past(reg_wdata[COUNT_W-1:0]))
        else $error("count register did not store the low sixteen bits");

    AST_READ_UPPER_ZERO: assert property (@(posedge sys_clk) disable iff (srst) // RQ17
        reg_rvalid |-> reg_rdata[DATA_W-1:COUNT_W] == 8'h00)
        else $error("upper byte of a read was not zero");

    AST_LED_B_ON_RISE: assert property (@(posedge sys_clk) disable iff (clr) // RQ2
        step && !hold_q && cnt_d == win_start[WIN_LED_B_ON] && cnt_d != win_end[WIN_LED_B_ON] |=> led_b_on)
        else $error("first LED not on at its start count");

    AST_LED_B_ON_FALL: assert property (@(posedge sys_clk) disable iff (clr) // RQ3
        step && cnt_d == win_end[WIN_LED_B_ON] |=> !led_b_on)
        else $error("first LED not off at its end count");

    AST_LED_B_SAMPLE_END: assert property (@(posedge sys_clk) disable iff (clr) // RQ1
        led_b_sample && step && cnt_d == win_end[WIN_LED_B_SAMPLE] |=> !led_b_sample)
        else $error("first LED sample window did not close at its end count");

    AST_AMB_B_CONVERT_RISE: assert property (@(posedge sys_clk) disable iff (clr) // RQ14
        step && !hold_q && cnt_d == win_start[WIN_AMB_B_CONVERT] && cnt_d != win_end[WIN_AMB_B_CONVERT]
        |=> amb_b_convert)
        else $error("ambient conversion did not start at its start count");

    AST_LED_A_ON_FALL: assert property (@(posedge sys_clk) disable iff (clr) // RQ9
        step && cnt_d == win_end[WIN_LED_A_ON] |=> !led_a_on)
        else $error("second LED not off at its end count");

    AST_LED_A_ON_RISE: assert property (@(posedge sys_clk) disable iff (clr) // RQ8
        step && !hold_q && cnt_d == win_start[WIN_LED_A_ON] && cnt_d != win_end[WIN_LED_A_ON] |=> led_a_on)
        else $error("second LED not on at its start count");

    AST_AMB_B_OPEN: assert property (@(posedge sys_clk) disable iff (clr) // RQ4
        opens[WIN_AMB_B_SAMPLE] |=> amb_b_sample)
        else $error("first ambient sample did not open");

    AST_AMB_B_CLOSE: assert property (@(posedge sys_clk) disable iff (clr) // RQ5
        closes[WIN_AMB_B_SAMPLE] |=> !amb_b_sample)
        else $error("first ambient sample did not close");

    AST_LED_A_SAMPLE_OPEN: assert property (@(posedge sys_clk) disable iff (clr) // RQ6
        opens[WIN_LED_A_SAMPLE] |=> led_a_sample)
        else $error("second LED sample did not open");

    AST_LED_A_SAMPLE_CLOSE: assert property (@(posedge sys_clk) disable iff (clr) // RQ7
        closes[WIN_LED_A_SAMPLE] |=> !led_a_sample)
        else $error("second LED sample did not close");

    AST_AMB_A_OPEN: assert property (@(posedge sys_clk) disable iff (clr) // RQ10
        opens[WIN_AMB_A_SAMPLE] |=> amb_a_sample)
        else $error("second ambient sample did not open");

    AST_AMB_A_CLOSE: assert property (@(posedge sys_clk) disable iff (clr) // RQ11
        closes[WIN_AMB_A_SAMPLE] |=> !amb_a_sample)
        else $error("second ambient sample did not close");

    AST_LED_B_CONV_OPEN: assert property (@(posedge sys_clk) disable iff (clr) // RQ12
        opens[WIN_LED_B_CONVERT] |=> led_b_convert)
        else $error("first conversion did not start");

    AST_LED_B_CONV_CLOSE: assert property (@(posedge sys_clk) disable iff (clr) // RQ13
        closes[WIN_LED_B_CONVERT] |=> !led_b_convert)
        else $error("first conversion did not end");

    AST_SOFT_RESET: assert property (@(posedge sys_clk) disable iff (srst) // RQ18
        sw_rst_q |=> count_q[0] == COUNT_RESET && period_q == PERIOD_RESET && !hold_q)
        else $error("software reset left registers set");

endmodule : ppt_timing_gen

// ===== logic/ppt_pkg.sv
package ppt_pkg;

    // Data and count widths.
    localparam int COUNT_W  = 16;
    localparam int DATA_W   = 24;
    localparam int ADDR_W   = 8;
    localparam int SLOT_W   = 4;
    localparam int NUM_SLOT = 16;
    localparam int NUM_WIN  = 8;

    // Timing: system clock and the timer clock that all counts refer to.
    localparam int       SYS_CLK_HZ   = 20_000_000;
    localparam int       TIMER_CLK_HZ = 4_000_000;
    localparam int       TICK_DIV     = SYS_CLK_HZ / TIMER_CLK_HZ;
    localparam logic [2:0] DIV_LAST   = 3'(TICK_DIV - 1);

    // Register addresses.
    localparam logic [ADDR_W-1:0] ADDR_CONTROL             = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_LED_B_SAMPLE_START  = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_LED_B_SAMPLE_END    = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_LED_B_ON_START      = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_LED_B_ON_END        = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_AMB_B_SAMPLE_START  = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_AMB_B_SAMPLE_END    = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_LED_A_SAMPLE_START  = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_LED_A_SAMPLE_END    = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_LED_A_ON_START      = 8'h09;
    localparam logic [ADDR_W-1:0] ADDR_LED_A_ON_END        = 8'h0A;
    localparam logic [ADDR_W-1:0] ADDR_AMB_A_SAMPLE_START  = 8'h0B;
    localparam logic [ADDR_W-1:0] ADDR_AMB_A_SAMPLE_END    = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_LED_B_CONVERT_START = 8'h0D;
    localparam logic [ADDR_W-1:0] ADDR_LED_B_CONVERT_END   = 8'h0E;
    localparam logic [ADDR_W-1:0] ADDR_AMB_B_CONVERT_START = 8'h0F;
    localparam logic [ADDR_W-1:0] ADDR_AMB_B_CONVERT_END   = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_PERIOD_LENGTH       = 8'h1D;

    // Control register bit positions.
    localparam int CTRL_READ_EN_BIT = 0;
    localparam int CTRL_HOLD_BIT    = 1;
    localparam int CTRL_SW_RST_BIT  = 3;

    // Reset values.
    localparam logic [COUNT_W-1:0] COUNT_RESET  = 16'h0000;
    localparam logic [COUNT_W-1:0] PERIOD_RESET = 16'h0000;

    // Window indices.
    localparam int WIN_LED_B_SAMPLE  = 0;
    localparam int WIN_LED_B_ON      = 1;
    localparam int WIN_AMB_B_SAMPLE  = 2;
    localparam int WIN_LED_A_SAMPLE  = 3;
    localparam int WIN_LED_A_ON      = 4;
    localparam int WIN_AMB_A_SAMPLE  = 5;
    localparam int WIN_LED_B_CONVERT = 6;
    localparam int WIN_AMB_B_CONVERT = 7;

    function automatic logic is_count_addr(input logic [ADDR_W-1:0] addr);
        return (addr >= ADDR_LED_B_SAMPLE_START) && (addr <= ADDR_AMB_B_CONVERT_END);
    endfunction : is_count_addr

    function automatic logic [SLOT_W-1:0] slot_of(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] diff;
        diff = addr - ADDR_LED_B_SAMPLE_START;
        return diff[SLOT_W-1:0];
    endfunction : slot_of

endpackage : ppt_pkg

// ===== logic/ppt_timing_if.sv
`timescale 1ns/1ps
interface ppt_timing_if;
    logic                          step;
    logic                          clear;
    logic [ppt_pkg::COUNT_W-1:0]   count_next;

    modport gen (output step, output clear, output count_next);
    modport win (input step, input clear, input count_next);
endinterface : ppt_timing_if

// ===== logic/ppt_window.sv
`timescale 1ns/1ps
module ppt_window
    import ppt_pkg::*;
(
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               srst,
    // Shared timing from the period counter
    ppt_timing_if.win               tim,
    // Programmed edges of this window
    input  wire logic [COUNT_W-1:0] start_cnt,
    input  wire logic [COUNT_W-1:0] end_cnt,
    // Window level
    output logic                    win_q
);

    logic hit_start;
    logic hit_end;
    logic win_d;

    assign hit_start = tim.step && (tim.count_next == start_cnt);
    assign hit_end   = tim.step && (tim.count_next == end_cnt);
    // End wins, so equal start and end counts give an empty window.
    assign win_d     = tim.clear ? 1'b0 : (hit_end ? 1'b0 : (hit_start ? 1'b1 : win_q)); // RQ20

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            win_q <= 1'b0;
        end else begin
            win_q <= win_d;
        end
    end

    AST_WIN_OPEN: assert property (@(posedge sys_clk) disable iff (srst) // RQ20
        hit_start && !hit_end && !tim.clear |=> win_q)
        else $error("window did not open at its start count");

    AST_WIN_CLOSE: assert property (@(posedge sys_clk) disable iff (srst) // RQ20
        hit_end |=> !win_q)
        else $error("window did not close at its end count");

    AST_WIN_STEADY: assert property (@(posedge sys_clk) disable iff (srst) // RQ20
        !tim.step && !tim.clear |=> win_q == $past(win_q))
        else $error("window changed between counter steps");

endmodule : ppt_window

// ===== bench/ppt_host_model.sv
`timescale 1ns/1ps
module ppt_host_model
    import ppt_pkg::*;
(
    // Clock
    input  wire logic               sys_clk,
    // Register port toward the device
    output logic                    reg_wr_en,
    output logic                    reg_rd_en,
    output logic      [ADDR_W-1:0]  reg_addr,
    output logic      [DATA_W-1:0]  reg_wdata,
    input  wire logic [DATA_W-1:0]  reg_rdata,
    input  wire logic               reg_rvalid
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 24'h000000;
    end

    task automatic write_reg(input logic [ADDR_W-1:0] addr, input logic [COUNT_W-1:0] val);
        @(negedge sys_clk);
        reg_wr_en = 1'b1;
        reg_addr  = addr;
        reg_wdata = {8'h00, val};
        @(negedge sys_clk);
        reg_wr_en = 1'b0;
        // Idle lines show inverted stale values so sampling outside a strobe cannot pass by luck.
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask : write_reg

    task automatic read_reg(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data, output logic ok);
        ok   = 1'b0;
        data = 24'h000000;
        @(negedge sys_clk);
        reg_rd_en = 1'b1;
        reg_addr  = addr;
        for (int i = 0; i < 3 && !ok; i++) begin
            @(negedge sys_clk);
            if (i == 0) begin
                reg_rd_en = 1'b0;
                reg_addr  = ~reg_addr;
            end
            if (reg_rvalid === 1'b1) begin
                data = reg_rdata;
                ok   = 1'b1;
            end
        end
    endtask : read_reg
endmodule : ppt_host_model

// ===== bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import ppt_pkg::*;
    logic               sys_clk;
    logic               srst;
    logic               reg_wr_en;
    logic               reg_rd_en;
    logic [ADDR_W-1:0]  reg_addr;
    logic [DATA_W-1:0]  reg_wdata;
    logic [DATA_W-1:0]  reg_rdata;
    logic               reg_rvalid;
    wire  [NUM_WIN-1:0] win;
    logic [COUNT_W-1:0] period_count;
    logic [COUNT_W-1:0] st [NUM_WIN];
    logic [COUNT_W-1:0] en [NUM_WIN];
    logic [COUNT_W-1:0] plen;
    logic [31:0]        lfsr;
    int                 bad_count;
    int                 n_checks;

    ppt_host_model host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
                         .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    ppt_timing_gen uut (.sys_clk(sys_clk), .srst(srst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .led_b_on(win[WIN_LED_B_ON]), .led_a_on(win[WIN_LED_A_ON]), .led_b_sample(win[WIN_LED_B_SAMPLE]),
        .led_a_sample(win[WIN_LED_A_SAMPLE]), .amb_b_sample(win[WIN_AMB_B_SAMPLE]),
        .amb_a_sample(win[WIN_AMB_A_SAMPLE]), .led_b_convert(win[WIN_LED_B_CONVERT]),
        .amb_b_convert(win[WIN_AMB_B_CONVERT]), .period_count(period_count));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    // Window k is open from its start count up to, not including, its end count.
    function automatic logic [NUM_WIN-1:0] exp_win(input logic [COUNT_W-1:0] c);
        for (int k = 0; k < NUM_WIN; k++) exp_win[k] = (c >= st[k]) && (c < en[k]);
    endfunction : exp_win

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task automatic check_word(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_win(input string name, input logic [NUM_WIN-1:0] exp, input logic [NUM_WIN-1:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : check_win

    task automatic check_read(input string name, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        logic [DATA_W-1:0] d;
        logic              ok;
        host.read_reg(a, d, ok);
        if (ok !== 1'b1) d = ~exp;
        check_word(name, exp, d);
    endtask : check_read

    task automatic program_regs();
        host.write_reg(ADDR_CONTROL, 16'h0003);
        for (int k = 0; k < NUM_WIN; k++) begin
            host.write_reg(ADDR_LED_B_SAMPLE_START + 8'(2 * k), st[k]);
            host.write_reg(ADDR_LED_B_SAMPLE_END + 8'(2 * k), en[k]);
        end
        host.write_reg(ADDR_PERIOD_LENGTH, plen);
        for (int k = 0; k < NUM_WIN; k++) begin
            check_read("start count", ADDR_LED_B_SAMPLE_START + 8'(2 * k), {8'h00, st[k]});
            check_read("end count", ADDR_LED_B_SAMPLE_END + 8'(2 * k), {8'h00, en[k]});
        end
        check_word("held count", 24'h000000, {8'h00, period_count});
        check_win("held windows", 8'h00, win);
        host.write_reg(ADDR_CONTROL, 16'h0001);
    endtask : program_regs

    task automatic run_and_check(input int ncyc);
        logic [COUNT_W-1:0] prev;
        int                 gap;
        bit                 armed;
        prev  = period_count;
        gap   = 0;
        armed = 1'b0;
        repeat (ncyc) begin
            @(negedge sys_clk);
            gap++;
            if (period_count !== prev) begin
                check_word("period count", {8'h00, (prev == plen) ? 16'h0000 : prev + 16'h0001}, {8'h00, period_count});
                if (armed) check_word("tick spacing", 24'(TICK_DIV), 24'(gap));
                armed = 1'b1;
                gap   = 0;
                prev  = period_count;
            end
            check_win("windows", exp_win(period_count), win);
        end
    endtask : run_and_check

    initial begin
        #(50 * 40000);
        bad_count++;
        $display("Error watchdog expected finish seen timeout");
        finish_test();
    end

    initial begin
        lfsr      = 32'h00010A90;
        bad_count = 0;
        n_checks  = 0;
        srst      = 1'b1;
        repeat (8) @(negedge sys_clk);
        srst = 1'b0;
        check_word("reset count", 24'h000000, {8'h00, period_count});
        check_win("reset windows", 8'h00, win);
        host.write_reg(ADDR_CONTROL, 16'h0001);
        for (int a = 1; a <= 16; a++) check_read("reset value", 8'(a), 24'h000000);
        check_read("reset period", ADDR_PERIOD_LENGTH, 24'h000000);
        host.write_reg(8'h20, 16'h1234);
        check_read("unmapped", 8'h20, 24'h000000);
        check_read("control", ADDR_CONTROL, 24'h000000);
        $display("Done reset values");
        // Round 0 holds the corner cases: a window closing on the last count and one with equal edges.
        for (int r = 0; r < 5; r++) begin
            lfsr = lfsr_next(lfsr);
            plen = (r == 0) ? 16'h0014 : 16'h0014 + lfsr[15:0] % 16'h0028;
            for (int k = 0; k < NUM_WIN; k++) begin
                lfsr  = lfsr_next(lfsr);
                st[k] = 16'h0001 + lfsr[15:0] % (plen - 16'h0001);
                lfsr  = lfsr_next(lfsr);
                en[k] = st[k] + 16'h0001 + lfsr[15:0] % (plen - st[k]);
            end
            if (r == 0) begin
                st[0] = 16'h0001;
                en[0] = plen;
                st[1] = 16'h0005;
                en[1] = 16'h0005;
            end
            program_regs();
            run_and_check(10 * (int'(plen) + 1) + 10);
            $display("Done round %0d period %0d", r, plen);
        end
        srst = 1'b1;
        @(negedge sys_clk);
        srst = 1'b0;
        check_word("mid reset count", 24'h000000, {8'h00, period_count});
        check_win("mid reset windows", 8'h00, win);
        host.write_reg(ADDR_LED_A_ON_START, 16'h00A5);
        check_read("readout off", ADDR_LED_A_ON_START, 24'h000000);
        host.write_reg(ADDR_CONTROL, 16'h0008);
        host.write_reg(ADDR_CONTROL, 16'h0001);
        check_read("soft reset", ADDR_LED_A_ON_START, 24'h000000);
        $display("Done resets");
        finish_test();
    end
endmodule : tb_top
